/* File: rtl/daa_air_if.sv */
`timescale 1ns/100ps
interface daa_air_if;
  import daa_pkg::*;
  logic                 we;
  logic [AIR_IDX_W-1:0] idx;
  logic [WORD_W-1:0]    wdata;
  logic [WORD_W-1:0]    rdata;
  modport core (output we, output idx, output wdata, input rdata);
  modport regs (input we, input idx, input wdata, output rdata);
endinterface : daa_air_if

/* File: rtl/daa_diag_access.sv */
`timescale 1ns/100ps
// Behaviour
// - Every diagnostic transfer traps unless privilege level equals zero.
// - Narrow implementation registers read into the low bits of the result.
// - Configuration register (index 0) resets to twelve zero bits.
// - Status word copy (index 1) resets to a 32-bit zero.
// - Branch tag write: entry base[5:0], set base[7:6], word {tag,dup bits}.
// - Branch tag entry holds 24-bit tag and three duplicated low tag bits.
// - Branch tag read uses same fields, returns 27 bits at the top.
// - Instruction tag write indexes by base low byte, stores 21 top bits.
// - Instruction tag entry holds 20-bit tag and a valid bit.
// - Instruction tag read indexes by low byte, returns 21 top bits.
// - Instruction cache write stores source word at selected entry, word.
// - Instruction cache read returns the selected 32-bit word.
// - Data cache write stores source word plus dirty and nru flag bits.
// - Data cache keeps data word per word, dirty and nru per entry.
// - Data cache read with field bit zero returns the data word.
// - Data cache read with field bit one returns dirty, nru in low bits.
module daa_diag_access
  import daa_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire daa_op_t           req_op,
  input  wire logic [PRIV_W-1:0] req_priv,
  input  wire logic [WORD_W-1:0] req_base,
  input  wire logic [WORD_W-1:0] req_src,
  input  wire logic [AIR_IDX_W-1:0] req_air_idx,
  output logic                   resp_valid,
  output logic                   resp_trap,
  output logic                   gr_we,
  output logic [WORD_W-1:0]      gr_data,
  output logic [CFG_W-1:0]       impl_config,
  output logic [WORD_W-1:0]      psw_copy,
  output logic [PWR_W-1:0]       power_mode,
  output logic [CKR_W-1:0]       standby_div
);
  daa_state_t            state_q;
  daa_state_t            state_d;
  logic                  take;
  logic                  priv_ok;
  logic                  do_op;
  logic                  bt_we;
  logic                  it_we;
  logic                  ic_we;
  logic                  dc_we;
  logic                  resp_valid_q;
  logic                  resp_trap_q;
  logic                  gr_we_q;
  logic [WORD_W-1:0]     gr_data_q;
  logic [WORD_W-1:0]     rd_word;
  logic [BT_SET_W-1:0]   bt_set;
  logic [BT_ENTRY_W-1:0] bt_entry;
  logic [IT_ENTRY_W-1:0] it_entry;
  logic [IC_ENTRY_W-1:0] ic_entry;
  logic [WSEL_W-1:0]     wsel;
  logic [DC_SET_W-1:0]   dc_set;
  logic [DC_ENTRY_W-1:0] dc_entry;
  logic [BT_WORD_W-1:0]  bt_sel;
  logic [IT_WORD_W-1:0]  it_sel;
  logic [WORD_W-1:0]     ic_sel;
  logic [WORD_W-1:0]     dc_sel;
  logic [DC_FLAG_W-1:0]  df_sel;

  // Arrays are plain storage and are not cleared by reset; software is
  // expected to initialise tags before enabling the caches.
  logic [BT_WORD_W-1:0]  btag_q  [BT_SETS][BT_ENTRIES];
  logic [IT_WORD_W-1:0]  itag_q  [IT_ENTRIES];
  logic [WORD_W-1:0]     icache_q [IC_ENTRIES][IC_WORDS];
  logic [WORD_W-1:0]     dcache_q [DC_SETS][DC_ENTRIES][DC_WORDS];
  logic [DC_FLAG_W-1:0]  dflag_q [DC_SETS][DC_ENTRIES];

  daa_air_if air ();

  daa_impl_regs u_regs (
    .core_clk    (core_clk),
    .rst         (rst),
    .air         (air.regs),
    .impl_config (impl_config),
    .psw_copy    (psw_copy),
    .power_mode  (power_mode),
    .standby_div (standby_div)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request acceptance and privilege check.
  assign req_ready = (state_q == ST_IDLE);
  assign take      = req_valid && req_ready;
  assign priv_ok   = (req_priv == PRIV_MOST);
  assign do_op     = take && priv_ok && is_diag(req_op);

  // Every write strobe is gated by do_op, so a trapped request moves nothing.
  assign bt_we = do_op && (req_op == OP_WRITE_BRANCH_TAG);
  assign it_we = do_op && (req_op == OP_WRITE_INSTR_TAG);
  assign ic_we = do_op && (req_op == OP_WRITE_INSTR_CACHE_WORD);
  assign dc_we = do_op && (req_op == OP_WRITE_DATA_CACHE_WORD);

  assign air.we    = do_op && (req_op == OP_WRITE_IMPL_REGISTER);
  assign air.idx   = req_air_idx;
  assign air.wdata = req_src;

  ////////////////////////////////////////////////////////////////////////////
  // Field selection from the base register.
  // Positions count from the least significant bit of the base word.
  // Software that numbers bits from the top must mirror every field,
  // so its bit k sits at bit 31-k here.
  assign bt_set   = req_base[BT_SET_LSB +: BT_SET_W];
  assign bt_entry = req_base[BT_ENTRY_LSB +: BT_ENTRY_W];
  assign it_entry = req_base[IT_ENTRY_LSB +: IT_ENTRY_W];
  assign ic_entry = req_base[IC_ENTRY_LSB +: IC_ENTRY_W];
  assign wsel     = req_base[WSEL_LSB +: WSEL_W];
  assign dc_set   = req_base[DC_SET_LSB +: DC_SET_W];
  assign dc_entry = req_base[DC_ENTRY_LSB +: DC_ENTRY_W];

  assign bt_sel = btag_q[bt_set][bt_entry];
  assign it_sel = itag_q[it_entry];
  assign ic_sel = icache_q[ic_entry][wsel];
  assign dc_sel = dcache_q[dc_set][dc_entry][wsel];
  assign df_sel = dflag_q[dc_set][dc_entry];

  ////////////////////////////////////////////////////////////////////////////
  // Array writes.
  always_ff @(posedge core_clk) begin
    if (bt_we) begin
      btag_q[bt_set][bt_entry] <= bt_word(req_base);
    end
  end

  always_ff @(posedge core_clk) begin
    if (it_we) begin
      itag_q[it_entry] <= req_base[IT_VAL_LSB +: IT_WORD_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (ic_we) begin
      icache_q[ic_entry][wsel] <= req_src;
    end
  end

  // The flags belong to the entry, so any word write of it rewrites them.
  always_ff @(posedge core_clk) begin
    if (dc_we) begin
      dcache_q[dc_set][dc_entry][wsel] <= req_src;
      dflag_q[dc_set][dc_entry] <= req_base[DC_FLAG_LSB +: DC_FLAG_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data formatting.
  always_comb begin
    case (req_op)
      OP_READ_IMPL_REGISTER: begin
        rd_word = air.rdata;
      end
      OP_READ_BRANCH_TAG: begin
        rd_word = {bt_sel, {BT_RD_LSB{1'b0}}};
      end
      OP_READ_INSTR_TAG: begin
        rd_word = {it_sel, {IT_RD_LSB{1'b0}}};
      end
      OP_READ_INSTR_CACHE_WORD: begin
        rd_word = ic_sel;
      end
      OP_READ_DATA_CACHE_WORD: begin
        if (req_base[DC_FIELD_BIT]) begin
          rd_word = {{(WORD_W-DC_FLAG_W){1'b0}}, df_sel};
        end else begin
          rd_word = dc_sel;
        end
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state: one request at a time, answer in the following cycle.
  always_comb begin
    case (state_q)
      ST_IDLE: state_d = take ? ST_RESP : ST_IDLE;
      ST_RESP: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      resp_valid_q <= 1'b0;
      resp_trap_q  <= 1'b0;
      gr_we_q      <= 1'b0;
    end else begin
      resp_valid_q <= take;
      resp_trap_q  <= take && is_diag(req_op) && !priv_ok;
      gr_we_q      <= do_op && is_read(req_op);
    end
  end

  // The destination holds its last value when nothing is to be written.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gr_data_q <= '0;
    end else if (do_op && is_read(req_op)) begin
      gr_data_q <= rd_word;
    end
  end

  assign resp_valid = resp_valid_q;
  assign resp_trap  = resp_trap_q;
  assign gr_we      = gr_we_q;
  assign gr_data    = gr_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [WORD_W-1:0] last_base_q;
  logic [WORD_W-1:0] last_src_q;

  always_ff @(posedge core_clk) begin
    last_base_q <= req_base;
    last_src_q  <= req_src;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_priv_take;
    take && is_diag(req_op) && !priv_ok;
  endsequence
  sequence s_trap_resp;
    resp_valid && resp_trap && !gr_we;
  endsequence
  sequence s_read_take(daa_op_t op);
    do_op && (req_op == op);
  endsequence

  priv_trap_a: assert property (s_priv_take |=> s_trap_resp)
    else $error("unprivileged request did not trap");
  priv_pass_a: assert property (
    (take && priv_ok) |=> (resp_valid && !resp_trap))
    else $error("privileged request trapped");
  trap_quiet_a: assert property (
    s_priv_take |-> !(bt_we || it_we || ic_we || dc_we || air.we)
      ##1 (!gr_we && $stable(gr_data)))
    else $error("trapped request changed state");
  air_narrow_a: assert property (
    (s_read_take(OP_READ_IMPL_REGISTER) and (req_air_idx == AIR_CFG))
      |=> (gr_data == {{(WORD_W-CFG_W){1'b0}}, $past(impl_config)}))
    else $error("configuration read misplaced");
  bt_write_a: assert property (
    s_read_take(OP_WRITE_BRANCH_TAG) |=>
      (btag_q[last_base_q[BT_SET_LSB +: BT_SET_W]]
             [last_base_q[BT_ENTRY_LSB +: BT_ENTRY_W]]
       == {last_base_q[31:8], last_base_q[10:8]}))
    else $error("branch tag write wrong");
  bt_read_a: assert property (
    s_read_take(OP_READ_BRANCH_TAG) |=>
      (gr_we && gr_data == {$past(bt_sel), 5'h00}))
    else $error("branch tag read wrong");
  it_write_a: assert property (
    s_read_take(OP_WRITE_INSTR_TAG) |=>
      (itag_q[last_base_q[7:0]] == last_base_q[31:11]))
    else $error("instruction tag write wrong");
  it_read_a: assert property (
    s_read_take(OP_READ_INSTR_TAG) |=>
      (gr_data == {$past(it_sel), 11'h000}))
    else $error("instruction tag read wrong");
  ic_write_a: assert property (
    s_read_take(OP_WRITE_INSTR_CACHE_WORD) |=>
      (icache_q[last_base_q[11:4]][last_base_q[3:2]] == last_src_q))
    else $error("instruction cache write wrong");
  ic_read_a: assert property (
    s_read_take(OP_READ_INSTR_CACHE_WORD) |=>
      (gr_we && gr_data == $past(ic_sel)))
    else $error("instruction cache read wrong");
  dc_write_a: assert property (
    s_read_take(OP_WRITE_DATA_CACHE_WORD) |=>
      ((dcache_q[last_base_q[1:0]][last_base_q[9:4]][last_base_q[3:2]]
        == last_src_q) &&
       (dflag_q[last_base_q[1:0]][last_base_q[9:4]]
        == last_base_q[11:10])))
    else $error("data cache write wrong");
  dc_data_a: assert property (
    (s_read_take(OP_READ_DATA_CACHE_WORD) and !req_base[10]) |=>
      (gr_data == $past(dc_sel)))
    else $error("data cache word read wrong");
  dc_flag_a: assert property (
    (s_read_take(OP_READ_DATA_CACHE_WORD) and req_base[10]) |=>
      (gr_data == {30'h0000_0000, $past(df_sel)}))
    else $error("data cache flag read wrong");
  one_busy_a: assert property (
    take |=> (!req_ready ##1 req_ready))
    else $error("request spacing wrong");

  // Response shape and side effects on the register block.
  // A stuck pulse would write the destination twice, so each is bounded.
  resp_pulse_a: assert property (
    resp_valid |=> !resp_valid)
    else $error("response held longer than one cycle");
  resp_qual_a: assert property (
    (resp_trap || gr_we) |-> resp_valid)
    else $error("trap or write strobe outside a response");
  ready_low_a: assert property (
    resp_valid |-> !req_ready)
    else $error("request accepted during a response");
  odd_op_a: assert property (
    (take && !is_diag(req_op)) |=>
      (resp_valid && !resp_trap && !gr_we && $stable(gr_data)))
    else $error("unknown operation had an effect");
  air_read_a: assert property (
    s_read_take(OP_READ_IMPL_REGISTER) |=>
      (gr_we && gr_data == $past(air.rdata)))
    else $error("implementation register read wrong");
  pwr_narrow_a: assert property (
    (s_read_take(OP_READ_IMPL_REGISTER) and (req_air_idx == AIR_PWR))
      |=> (gr_data == {{(WORD_W-PWR_W){1'b0}}, $past(power_mode)}))
    else $error("power mode read misplaced");
  psw_write_a: assert property (
    (s_read_take(OP_WRITE_IMPL_REGISTER) and (req_air_idx == AIR_PSW))
      |=> (psw_copy == last_src_q))
    else $error("status word copy write lost");
  trap_regs_a: assert property (
    s_priv_take |=> ($stable(impl_config) && $stable(psw_copy) &&
      $stable(power_mode) && $stable(standby_div)))
    else $error("trapped request changed a register");
  wr_no_dest_a: assert property (
    (do_op && !is_read(req_op)) |=> (!gr_we && $stable(gr_data)))
    else $error("write request touched the destination");
endmodule : daa_diag_access

/* File: rtl/daa_impl_regs.sv */
`timescale 1ns/100ps
module daa_impl_regs
  import daa_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  daa_air_if.regs                air,
  output logic [CFG_W-1:0]       impl_config,
  output logic [WORD_W-1:0]      psw_copy,
  output logic [PWR_W-1:0]       power_mode,
  output logic [CKR_W-1:0]       standby_div
);
  logic [CFG_W-1:0]  cfg_q;
  logic [WORD_W-1:0] psw_q;
  logic [WORD_W-1:0] halt_status_backup_q;
  logic [WORD_W-1:0] idr_q;
  logic [WORD_W-1:0] itr_q;
  logic [PWR_W-1:0]  pwr_q;
  logic [CKR_W-1:0]  ckr_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_q  <= CFG_RST;
      psw_q  <= PSW_RST;
      halt_status_backup_q <= DBG_RST;
      idr_q  <= DBG_RST;
      itr_q  <= DBG_RST;
      pwr_q  <= PWR_RST;
      ckr_q  <= CKR_RST;
    end else if (air.we) begin
      case (air.idx)
        AIR_CFG:  cfg_q  <= air.wdata[CFG_W-1:0];
        AIR_PSW:  psw_q  <= air.wdata;
        AIR_HALT_STATUS_BACKUP: halt_status_backup_q <= air.wdata;
        AIR_IDR:  idr_q  <= air.wdata;
        AIR_ITR:  itr_q  <= air.wdata;
        AIR_PWR:  pwr_q  <= air.wdata[PWR_W-1:0];
        AIR_CKR:  ckr_q  <= air.wdata[CKR_W-1:0];
        default:  ;
      endcase
    end
  end

  // Narrow registers land in the low bits; unimplemented indices read zero.
  always_comb begin
    case (air.idx)
      AIR_CFG:  air.rdata = {{(WORD_W-CFG_W){1'b0}}, cfg_q};
      AIR_PSW:  air.rdata = psw_q;
      AIR_HALT_STATUS_BACKUP: air.rdata = halt_status_backup_q;
      AIR_IDR:  air.rdata = idr_q;
      AIR_ITR:  air.rdata = itr_q;
      AIR_PWR:  air.rdata = {{(WORD_W-PWR_W){1'b0}}, pwr_q};
      AIR_CKR:  air.rdata = {{(WORD_W-CKR_W){1'b0}}, ckr_q};
      default:  air.rdata = '0;
    endcase
  end

  assign impl_config = cfg_q;
  assign psw_copy    = psw_q;
  assign power_mode  = pwr_q;
  assign standby_div = ckr_q;

  reset_vals_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(rst) |-> (cfg_q == CFG_RST) && (psw_q == PSW_RST))
    else $error("impl registers not zero after reset");
endmodule : daa_impl_regs

/* File: rtl/daa_pkg.sv */
package daa_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned AIR_IDX_W = 4;
  localparam int unsigned PRIV_W = 2;
  localparam logic [PRIV_W-1:0] PRIV_MOST = 2'h0;
  //////////////////////////////////////////////////////////////////////////
  // Implementation-dependent register indices, widths and reset values.
  localparam logic [AIR_IDX_W-1:0] AIR_CFG = 4'h0;
  localparam logic [AIR_IDX_W-1:0] AIR_PSW = 4'h1;
  localparam logic [AIR_IDX_W-1:0] AIR_HALT_STATUS_BACKUP = 4'h7;
  localparam logic [AIR_IDX_W-1:0] AIR_IDR = 4'h9;
  localparam logic [AIR_IDX_W-1:0] AIR_ITR = 4'ha;
  localparam logic [AIR_IDX_W-1:0] AIR_PWR = 4'hb;
  localparam logic [AIR_IDX_W-1:0] AIR_CKR = 4'hc;
  localparam int unsigned CFG_W = 12;
  localparam int unsigned PWR_W = 3;
  localparam int unsigned CKR_W = 8;
  localparam logic [CFG_W-1:0]  CFG_RST = 12'h000;
  localparam logic [WORD_W-1:0] PSW_RST = 32'h0000_0000;
  localparam logic [WORD_W-1:0] DBG_RST = 32'h0000_0000;
  localparam logic [PWR_W-1:0]  PWR_RST = 3'h0;
  localparam logic [CKR_W-1:0]  CKR_RST = 8'h00;
  //////////////////////////////////////////////////////////////////////////
  // Array geometry and base-register field positions (bit 0 is the LSB).
  localparam int unsigned BT_SETS = 4;
  localparam int unsigned BT_ENTRIES = 64;
  localparam int unsigned BT_SET_W = 2;
  localparam int unsigned BT_ENTRY_W = 6;
  localparam int unsigned BT_WORD_W = 27;
  localparam int unsigned BT_ENTRY_LSB = 0;
  localparam int unsigned BT_SET_LSB = 6;
  localparam int unsigned BT_TAG_LSB = 8;
  localparam int unsigned BT_TAG_W = 24;
  localparam int unsigned BT_DUP_W = 3;
  localparam int unsigned BT_RD_LSB = 5;
  localparam int unsigned IT_ENTRIES = 256;
  localparam int unsigned IT_ENTRY_W = 8;
  localparam int unsigned IT_ENTRY_LSB = 0;
  localparam int unsigned IT_WORD_W = 21;
  localparam int unsigned IT_VAL_LSB = 11;
  localparam int unsigned IT_RD_LSB = 11;
  localparam int unsigned IC_ENTRIES = 256;
  localparam int unsigned IC_WORDS = 4;
  localparam int unsigned IC_ENTRY_W = 8;
  localparam int unsigned IC_ENTRY_LSB = 4;
  localparam int unsigned WSEL_W = 2;
  localparam int unsigned WSEL_LSB = 2;
  localparam int unsigned DC_SETS = 4;
  localparam int unsigned DC_ENTRIES = 64;
  localparam int unsigned DC_WORDS = 4;
  localparam int unsigned DC_SET_W = 2;
  localparam int unsigned DC_SET_LSB = 0;
  localparam int unsigned DC_ENTRY_W = 6;
  localparam int unsigned DC_ENTRY_LSB = 4;
  localparam int unsigned DC_FLAG_W = 2;
  localparam int unsigned DC_FLAG_LSB = 10;
  localparam int unsigned DC_FIELD_BIT = 10;
  //////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    OP_READ_IMPL_REGISTER      = 4'h0,
    OP_WRITE_IMPL_REGISTER     = 4'h1,
    OP_WRITE_BRANCH_TAG        = 4'h2,
    OP_READ_BRANCH_TAG         = 4'h3,
    OP_WRITE_INSTR_TAG         = 4'h4,
    OP_READ_INSTR_TAG          = 4'h5,
    OP_WRITE_INSTR_CACHE_WORD  = 4'h6,
    OP_READ_INSTR_CACHE_WORD   = 4'h7,
    OP_WRITE_DATA_CACHE_WORD   = 4'h8,
    OP_READ_DATA_CACHE_WORD    = 4'h9,
    OP_NONE                    = 4'hf
  } daa_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } daa_state_t;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic is_diag(input daa_op_t op);
    return (op != OP_NONE) && (op <= OP_READ_DATA_CACHE_WORD);
  endfunction : is_diag
  // The register read shares code 0 with no odd bit, so it is named apart.
  function automatic logic is_read(input daa_op_t op);
    return (op == OP_READ_IMPL_REGISTER) ||
           (is_diag(op) && (op != OP_WRITE_IMPL_REGISTER) && op[0]);
  endfunction : is_read
  function automatic logic [BT_WORD_W-1:0] bt_word(input logic [31:0] b);
    return {b[BT_TAG_LSB +: BT_TAG_W], b[BT_TAG_LSB +: BT_DUP_W]};
  endfunction : bt_word
endpackage : daa_pkg

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import daa_pkg::*;
;
  logic                 core_clk;
  logic                 rst;
  logic                 req_valid;
  logic                 req_ready;
  daa_op_t              req_op;
  logic [PRIV_W-1:0]    req_priv;
  logic [WORD_W-1:0]    req_base;
  logic [WORD_W-1:0]    req_src;
  logic [AIR_IDX_W-1:0] req_air_idx;
  logic                 resp_valid;
  logic                 resp_trap;
  logic                 gr_we;
  logic [WORD_W-1:0]    gr_data;
  logic [CFG_W-1:0]     impl_config;
  logic [WORD_W-1:0]    psw_copy;
  logic [PWR_W-1:0]     power_mode;
  logic [CKR_W-1:0]     standby_div;
  int                   err_total;
  int                   total_checks;
  logic                 ghost_en;
  logic [31:0]          last_gr;
  logic [31:0]          last_base [5];
  logic [31:0]          air_m [16];
  logic [26:0]          bt_m [int];
  logic [20:0]          it_m [int];
  logic [31:0]          ic_m [int];
  logic [31:0]          dc_m [int];
  logic [1:0]           fl_m [int];
  logic [3:0]           impl_idx [7] = '{4'h0, 4'h1, 4'h7, 4'h9, 4'ha,
                                         4'hb, 4'hc};

  daa_diag_access daa_diag_access_i (
    .core_clk    (core_clk),
    .rst         (rst),
    .req_valid   (req_valid),
    .req_ready   (req_ready),
    .req_op      (req_op),
    .req_priv    (req_priv),
    .req_base    (req_base),
    .req_src     (req_src),
    .req_air_idx (req_air_idx),
    .resp_valid  (resp_valid),
    .resp_trap   (resp_trap),
    .gr_we       (gr_we),
    .gr_data     (gr_data),
    .impl_config (impl_config),
    .psw_copy    (psw_copy),
    .power_mode  (power_mode),
    .standby_div (standby_div)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      err_total++;
    end
  endtask : check

  function automatic logic [31:0] air_mask(input logic [3:0] i);
    case (i)
      4'h0:                   return 32'h0000_0fff;
      4'h1, 4'h7, 4'h9, 4'ha: return 32'hffff_ffff;
      4'hb:                   return 32'h0000_0007;
      4'hc:                   return 32'h0000_00ff;
      default:                return 32'h0000_0000;
    endcase
  endfunction : air_mask

  function automatic daa_op_t wr_op(input int k);
    return daa_op_t'(4'(k == 0 ? 1 : 2 * k));
  endfunction : wr_op

  function automatic daa_op_t rd_op(input int k);
    return daa_op_t'(4'(k == 0 ? 0 : 2 * k + 1));
  endfunction : rd_op

  task automatic check_regs();
    check(32'(impl_config), air_m[0]);
    check(psw_copy, air_m[1]);
    check(32'(power_mode), air_m[11]);
    check(32'(standby_div), air_m[12]);
  endtask : check_regs

  // Called at a falling edge; returns at the falling edge after the response cycle.
  task automatic do_op(input daa_op_t op, input logic [1:0] priv,
                       input logic [31:0] b, input logic [31:0] s,
                       input logic [3:0] idx);
    logic [31:0] exp;
    logic        trap;
    logic        rd;
    exp = last_gr;
    trap = (4'(op) <= 4'h9) && (priv != PRIV_MOST);
    rd = !trap && (op inside {OP_READ_IMPL_REGISTER, OP_READ_BRANCH_TAG,
      OP_READ_INSTR_TAG, OP_READ_INSTR_CACHE_WORD, OP_READ_DATA_CACHE_WORD});
    if (!trap) begin
      case (op)
        OP_READ_IMPL_REGISTER:     exp = air_m[idx];
        OP_READ_BRANCH_TAG:        exp = {bt_m[b[7:0]], 5'h00};
        OP_READ_INSTR_TAG:         exp = {it_m[b[7:0]], 11'h000};
        OP_READ_INSTR_CACHE_WORD:  exp = ic_m[b[11:2]];
        OP_READ_DATA_CACHE_WORD: begin
          exp = {30'h0, fl_m[{b[9:4], b[1:0]}]};
          if (!b[10]) exp = dc_m[b[9:0]];
        end
        OP_WRITE_IMPL_REGISTER:    air_m[idx] = s & air_mask(idx);
        OP_WRITE_BRANCH_TAG:       bt_m[b[7:0]] = {b[31:8], b[10:8]};
        OP_WRITE_INSTR_TAG:        it_m[b[7:0]] = b[31:11];
        OP_WRITE_INSTR_CACHE_WORD: ic_m[b[11:2]] = s;
        OP_WRITE_DATA_CACHE_WORD: begin
          dc_m[b[9:0]] = s;
          fl_m[{b[9:4], b[1:0]}] = b[11:10];
        end
        default: ;
      endcase
    end
    check(32'(req_ready), 32'h1);
    req_valid = 1'b1;
    req_op = op;
    req_priv = priv;
    req_base = b;
    req_src = s;
    req_air_idx = idx;
    @(posedge core_clk);
    @(negedge core_clk);
    // A request offered while ready is low must be dropped, not queued.
    req_valid = ghost_en;
    req_op = OP_WRITE_IMPL_REGISTER;
    req_priv = PRIV_MOST;
    req_base = ~b;
    req_src = ~air_m[1];
    req_air_idx = 4'h1;
    check(32'(req_ready), 32'h0);
    check(32'(resp_valid), 32'h1);
    check(32'(resp_trap), 32'(trap));
    check(32'(gr_we), 32'(rd));
    check(gr_data, exp);
    check_regs();
    last_gr = exp;
    @(negedge core_clk);
    check(32'(resp_valid), 32'h0);
    check_regs();
  endtask : do_op

  task automatic do_reset();
    rst = 1'b1;
    req_valid = 1'b0;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    foreach (air_m[i]) air_m[i] = 32'h0;
    last_gr = 32'h0;
    check(32'(resp_valid), 32'h0);
    check(gr_data, 32'h0);
    check_regs();
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int unsigned seed;
    int          k;
    logic [31:0] b;
    logic [3:0]  ix;
    logic [1:0]  p;
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = OP_NONE;
    req_priv = 2'h0;
    req_base = 32'h0;
    req_src = 32'h0;
    req_air_idx = 4'h0;
    ghost_en = 1'b0;
    err_total = 0;
    total_checks = 0;
    seed = $urandom(98);
    do_reset();
    for (int i = 0; i < 16; i++) begin
      do_op(OP_READ_IMPL_REGISTER, 2'h0, $urandom, $urandom, 4'(i));
      do_op(OP_WRITE_IMPL_REGISTER, 2'h0, $urandom, 32'hffff_ffff, 4'(i));
      do_op(OP_READ_IMPL_REGISTER, 2'h0, $urandom, $urandom, 4'(i));
    end
    // Each kind is written three times here, so later reads never hit empty entries.
    for (k = 0; k < 5; k++) begin
      for (int q = 1; q < 4; q++) begin
        b = $urandom;
        ix = impl_idx[$urandom % 7];
        last_base[k] = b;
        do_op(wr_op(k), 2'h0, b, $urandom, ix);
        b = b ^ (k == 3 ? 32'hffff_f000 : 32'hffff_f800);
        do_op(wr_op(k), 2'(q), b, $urandom, ix);
        do_op(rd_op(k), 2'(q), last_base[k], $urandom, ix);
        do_op(rd_op(k), 2'h0, last_base[k], $urandom, ix);
      end
    end
    for (int n = 0; n < 300; n++) begin
      k = $urandom % 5;
      p = ($urandom % 8 == 0) ? 2'(1 + $urandom % 3) : 2'h0;
      ghost_en = 1'($urandom);
      if ($urandom % 2) begin
        b = last_base[k];
        if (k == 4) b[10] = 1'($urandom);
        do_op(rd_op(k), p, b, $urandom, 4'($urandom));
      end else begin
        b = ($urandom % 2) ? last_base[k] : $urandom;
        if (p == 2'h0) last_base[k] = b;
        do_op(wr_op(k), p, b, $urandom, 4'($urandom));
      end
    end
    ghost_en = 1'b0;
    do_op(OP_WRITE_BRANCH_TAG, 2'h0, 32'hffff_ffff, 32'h0, 4'h0);
    do_op(OP_WRITE_BRANCH_TAG, 2'h0, 32'h0000_0000, 32'h0, 4'h0);
    do_op(OP_READ_BRANCH_TAG, 2'h0, 32'h0000_00ff, 32'h0, 4'h0);
    do_op(OP_WRITE_DATA_CACHE_WORD, 2'h0, 32'h0410, 32'h1234_5678, 4'h0);
    do_op(OP_WRITE_DATA_CACHE_WORD, 2'h0, 32'h0814, 32'h9abc_def0, 4'h0);
    do_op(OP_READ_DATA_CACHE_WORD, 2'h0, 32'h0010, 32'h0, 4'h0);
    do_op(OP_READ_DATA_CACHE_WORD, 2'h0, 32'h0414, 32'h0, 4'h0);
    do_op(daa_op_t'(4'hd), 2'h1, $urandom, $urandom, 4'h1);
    do_op(OP_NONE, 2'h2, $urandom, $urandom, 4'h0);
    do_reset();
    do_op(OP_READ_INSTR_TAG, 2'h0, last_base[2], $urandom, 4'h0);
    test_done();
  end

  // The whole run needs about 850 cycles; this leaves a wide margin.
  initial begin
    repeat (6000) @(posedge core_clk);
    err_total++;
    test_done();
  end
endmodule : tb_top
